// ===== logic/charger_mode_control.sv
`timescale 1ns/1ps
// Operation
// - Charge enable pin low/floating disables charging
// - High-current pin high selects 1500 mA limit
// - Limit pin low 100 mA, high 500 mA
// - Pin levels set initial parameters after power-up
// - Written register field overrides matching pin
// - Supply connect/disconnect returns control to pins
// - Bit D0 of charge_mode_control enables all charging
// - Bit D3 disables regulator; isolation follows enable
// - Regulator off, isolation on, any battery
// - Charger off: regulator 4.3 V, isolation off
// - Below dead threshold: trickle, regulator, isolation off
// - Weak uses trickle, fast does not
// - No battery: trickle/isolation off, regulator on
// - Shorted battery: trickle on, isolation off
// - Battery-OK output active from weak threshold
// - Limit field resets to 100 mA, writes override
module charger_mode_control #(
  parameter logic [6:0] DEV_ADDR = charger_pkg::DEV_ADDR_DEF  // Arbitrary bus address
) (
  input  wire logic       ref_clk,           // 50 MHz core clock
  input  wire logic       arst_n,            // Async reset, active low
  input  wire logic       ce,                // Clock enable, freezes all state
  input  wire logic       sclIn,             // Serial clock pin
  input  wire logic       sdaIn,             // Serial data pin level
  output logic            sdaOut,            // Serial data drive value, always low
  output logic            sdaOe,             // Serial data pull-down enable
  input  wire logic       chargeEnablePin,   // Charge enable pin
  input  wire logic       highCurrentPin,    // High-current select pin
  input  wire logic       limitSelectPin,    // Current-limit select pin
  input  wire logic       supplyPresent,     // Supply input detected
  input  wire logic       batBelowDead,      // Battery below dead threshold
  input  wire logic       batBelowWeak,      // Battery below weak threshold
  input  wire logic       batAbsent,         // No battery detected
  input  wire logic       batShorted,        // Battery rail shorted
  output logic            trickleOn,         // Trickle path on
  output logic            regulatorOn,       // Regulator holds rail at 4.3 V
  output logic            chargeLoopOn,      // Charger loop holds rail at 3.4 V or more
  output logic            isolationOn,       // Battery isolation FET on
  output logic [3:0]      inputLimitCode,    // Applied input current limit
  output logic [8:0]      modeOut,           // One-hot operating mode
  output logic            batteryOkOut,      // Battery-OK drive value, always low
  output logic            batteryOkOe        // Battery-OK pull-down enable
);

  typedef struct packed {
    charger_pkg::ser_state_t ser;
    charger_pkg::ser_state_t after;
    logic [7:0]              shift;
    logic [3:0]              cnt;
    logic [7:0]              ptr;
    logic                    sclPrev;
    logic                    sdaPrev;
    logic                    sdaOe;
    logic                    chgBit;
    logic                    chgOvr;
    logic                    regDis;
    logic [3:0]              limField;
    logic                    limOvr;
    logic                    supplyPrev;
    charger_pkg::mode_t      mode;
    logic                    trickleOn;
    logic                    regulatorOn;
    logic                    chargeLoopOn;
    logic                    isolationOn;
    logic                    batOkOe;
    logic [3:0]              limit;
  } state_t;
  state_t st_reg;
  state_t st_next;
  logic [9:0] syncLv;
  logic       sclS, sdaS, chgPinS, hiPinS, limPinS, supplyS, deadS, weakS, absentS, shortS;
  logic       chgEff;
  logic       wrStrobe;
  logic [3:0] pinLimit;
  // All outside levels go through the three-stage synchroniser
  level_sync #(
    .WIDTH     (10),
    .RESET_VAL (10'h003)
  ) u_sync (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .ce       (ce),
    .asyncIn  ({batShorted, batAbsent, batBelowWeak, batBelowDead, supplyPresent,
                limitSelectPin, highCurrentPin, chargeEnablePin, sdaIn, sclIn}),
    .levelOut (syncLv)
  );
  assign {shortS, absentS, weakS, deadS, supplyS, limPinS, hiPinS, chgPinS, sdaS, sclS} = syncLv;
  // Register read decode
  function automatic logic [7:0] readReg(input logic [7:0] addr, input state_t s,
                                         input logic effChg);
    logic [7:0] d;
    d = charger_pkg::UNMAPPED_DATA;
    case (addr)
      charger_pkg::LIMIT_CTRL_ADDR: d[charger_pkg::LIM_MSB:charger_pkg::LIM_LSB] = s.limit;
      charger_pkg::MODE_CTRL_ADDR: begin
        d[charger_pkg::CHG_EN_BIT]  = effChg;
        d[charger_pkg::REG_DIS_BIT] = s.regDis;
      end
      charger_pkg::STATUS_ADDR: d = {s.isolationOn, s.chargeLoopOn, s.regulatorOn, s.trickleOn,
                                     s.batOkOe, s.chgOvr, s.limOvr, s.supplyPrev};
      default: d = charger_pkg::UNMAPPED_DATA;
    endcase
    return d;
  endfunction : readReg
  // Pin-derived values; the high-current pin outranks the limit pin
  always_comb begin
    chgEff   = st_reg.chgOvr ? st_reg.chgBit : chgPinS;
    pinLimit = hiPinS ? charger_pkg::LIM_1500MA :
               (limPinS ? charger_pkg::LIM_500MA : charger_pkg::LIM_100MA);
  end
  // Serial register port, mode selection and output decode
  always_comb begin
    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;
    logic [7:0] rd;
    sclRise   = sclS && !st_reg.sclPrev;
    sclFall   = !sclS && st_reg.sclPrev;
    startCond = sclS && st_reg.sclPrev && st_reg.sdaPrev && !sdaS;
    stopCond  = sclS && st_reg.sclPrev && !st_reg.sdaPrev && sdaS;
    rd        = readReg(st_reg.ptr, st_reg, chgEff);
    wrStrobe  = 1'b0;
    st_next         = st_reg;
    st_next.sclPrev = sclS;
    st_next.sdaPrev = sdaS;

    // Supply edge hands control back to the pins; a write in the same cycle wins
    st_next.supplyPrev = supplyS;
    if (supplyS != st_reg.supplyPrev) begin
      st_next.chgOvr = 1'b0;
      st_next.limOvr = 1'b0;
    end

    if (startCond) begin
      st_next.ser   = charger_pkg::SER_ADDR;
      st_next.cnt   = 4'h0;
      st_next.sdaOe = 1'b0;
    end else if (stopCond) begin
      st_next.ser   = charger_pkg::SER_IDLE;
      st_next.sdaOe = 1'b0;
    end else begin
      case (st_reg.ser)
        charger_pkg::SER_IDLE: st_next.sdaOe = 1'b0;
        charger_pkg::SER_ADDR, charger_pkg::SER_REG, charger_pkg::SER_WDAT: begin
          if (sclRise) begin
            st_next.shift = {st_reg.shift[6:0], sdaS};
            st_next.cnt   = st_reg.cnt + 4'h1;
          end else if (sclFall && st_reg.cnt == charger_pkg::BITS_PER_BYTE) begin
            st_next.ser   = charger_pkg::SER_ACK;
            st_next.sdaOe = 1'b1;
            if (st_reg.ser == charger_pkg::SER_ADDR) begin
              if (st_reg.shift[7:1] != DEV_ADDR) begin
                st_next.ser   = charger_pkg::SER_IDLE;
                st_next.sdaOe = 1'b0;
              end
              st_next.after = st_reg.shift[0] ? charger_pkg::SER_RDAT : charger_pkg::SER_REG;
            end else if (st_reg.ser == charger_pkg::SER_REG) begin
              st_next.ptr   = st_reg.shift;
              st_next.after = charger_pkg::SER_WDAT;
            end else begin
              wrStrobe      = 1'b1;
              st_next.ptr   = st_reg.ptr + 8'h01;
              st_next.after = charger_pkg::SER_WDAT;
              // A write takes the field over from its pin
              if (st_reg.ptr == charger_pkg::MODE_CTRL_ADDR) begin
                st_next.chgBit = st_reg.shift[charger_pkg::CHG_EN_BIT];
                st_next.regDis = st_reg.shift[charger_pkg::REG_DIS_BIT];
                st_next.chgOvr = 1'b1;
              end else if (st_reg.ptr == charger_pkg::LIMIT_CTRL_ADDR) begin
                st_next.limField = st_reg.shift[charger_pkg::LIM_MSB:charger_pkg::LIM_LSB];
                st_next.limOvr   = 1'b1;
              end
            end
          end
        end
        charger_pkg::SER_ACK: begin
          if (sclFall) begin
            st_next.ser   = st_reg.after;
            st_next.cnt   = 4'h0;
            st_next.sdaOe = 1'b0;
            if (st_reg.after == charger_pkg::SER_RDAT) begin
              st_next.shift = rd;
              st_next.ptr   = st_reg.ptr + 8'h01;
              st_next.sdaOe = !rd[7];
            end
          end
        end
        charger_pkg::SER_RDAT: begin
          if (sclRise) begin
            st_next.cnt = st_reg.cnt + 4'h1;
          end else if (sclFall) begin
            if (st_reg.cnt == charger_pkg::BITS_PER_BYTE) begin
              st_next.ser   = charger_pkg::SER_MACK;
              st_next.sdaOe = 1'b0;
            end else begin
              st_next.shift = {st_reg.shift[6:0], 1'b0};
              st_next.sdaOe = !st_reg.shift[6];
            end
          end
        end
        charger_pkg::SER_MACK: begin
          // Master acknowledge continues the read, a not-acknowledge ends it
          if (sclRise) begin
            st_next.ser   = sdaS ? charger_pkg::SER_IDLE : charger_pkg::SER_ACK;
            st_next.after = charger_pkg::SER_RDAT;
          end
        end
        default: begin
          st_next.ser   = charger_pkg::SER_IDLE;
          st_next.sdaOe = 1'b0;
        end
      endcase
    end

    // Applied limit: override field if written, else pins
    st_next.limit = st_reg.limOvr ? st_reg.limField : pinLimit;

    // Mode selection, battery faults outrank voltage bands
    if (!supplyS) begin
      st_next.mode = charger_pkg::MODE_STANDBY;
    end else if (st_reg.regDis) begin
      st_next.mode = chgEff ? charger_pkg::MODE_SYS_OFF : charger_pkg::MODE_SUSPEND;
    end else if (!chgEff) begin
      st_next.mode = charger_pkg::MODE_REG_ONLY;
    end else if (shortS) begin
      st_next.mode = charger_pkg::MODE_SHORTED;
    end else if (absentS) begin
      st_next.mode = charger_pkg::MODE_NO_BAT;
    end else if (deadS) begin
      st_next.mode = charger_pkg::MODE_TRICKLE;
    end else if (weakS) begin
      st_next.mode = charger_pkg::MODE_WEAK;
    end else begin
      st_next.mode = charger_pkg::MODE_FAST;
    end

    // Path controls per mode
    st_next.trickleOn    = 1'b0;
    st_next.regulatorOn  = 1'b0;
    st_next.chargeLoopOn = 1'b0;
    st_next.isolationOn  = 1'b0;
    case (st_next.mode)
      charger_pkg::MODE_STANDBY:  st_next.isolationOn = 1'b1;
      charger_pkg::MODE_SUSPEND:  st_next.isolationOn = 1'b1;
      charger_pkg::MODE_SYS_OFF:  st_next.isolationOn = 1'b0;
      charger_pkg::MODE_REG_ONLY: st_next.regulatorOn = 1'b1;
      charger_pkg::MODE_TRICKLE: begin
        st_next.trickleOn   = 1'b1;
        st_next.regulatorOn = 1'b1;
      end
      charger_pkg::MODE_WEAK: begin
        st_next.trickleOn    = 1'b1;
        st_next.chargeLoopOn = 1'b1;
      end
      charger_pkg::MODE_FAST:     st_next.chargeLoopOn = 1'b1;
      charger_pkg::MODE_NO_BAT:   st_next.regulatorOn = 1'b1;
      charger_pkg::MODE_SHORTED: begin
        st_next.trickleOn   = 1'b1;
        st_next.regulatorOn = 1'b1;
      end
      default: st_next.isolationOn = 1'b1;
    endcase

    // Battery OK pulls down once the weak threshold is reached
    st_next.batOkOe = !weakS && !deadS && !absentS && !shortS;
  end

  // Reset leaves every override clear, so pins rule after power-up
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '{ser: charger_pkg::SER_IDLE, after: charger_pkg::SER_IDLE,
                  shift: 8'h00, cnt: 4'h0, ptr: 8'h00, sclPrev: 1'b1, sdaPrev: 1'b1,
                  sdaOe: 1'b0, chgBit: charger_pkg::CHG_EN_RESET, chgOvr: 1'b0,
                  regDis: charger_pkg::REG_DIS_RESET, limField: charger_pkg::LIM_RESET,
                  limOvr: 1'b0, supplyPrev: 1'b0, mode: charger_pkg::MODE_STANDBY,
                  trickleOn: 1'b0, regulatorOn: 1'b0, chargeLoopOn: 1'b0,
                  isolationOn: 1'b1, batOkOe: 1'b0, limit: charger_pkg::LIM_RESET};
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register; sdaOut and batteryOkOut are tied low
  assign sdaOut         = 1'b0;
  assign sdaOe          = st_reg.sdaOe;
  assign trickleOn      = st_reg.trickleOn;
  assign regulatorOn    = st_reg.regulatorOn;
  assign chargeLoopOn   = st_reg.chargeLoopOn;
  assign isolationOn    = st_reg.isolationOn;
  assign inputLimitCode = st_reg.limit;
  assign modeOut        = st_reg.mode;
  assign batteryOkOut   = 1'b0;
  assign batteryOkOe    = st_reg.batOkOe;
  // Checks tying outputs to their causes
  chk_chg_pin_off: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ce && supplyS && !st_reg.regDis && !st_reg.chgOvr && !chgPinS
      |=> modeOut == charger_pkg::MODE_REG_ONLY)
    else $error("charging not disabled by low enable pin");
  chk_hi_limit: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ce && !st_reg.limOvr && hiPinS |=> inputLimitCode == charger_pkg::LIM_1500MA)
    else $error("high-current pin did not give 1500 mA");
  chk_lo_limit: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ce && !st_reg.limOvr && !hiPinS
      |=> inputLimitCode == ($past(limPinS) ? charger_pkg::LIM_500MA : charger_pkg::LIM_100MA))
    else $error("limit pin mapping wrong");
  chk_limit_ovr: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ce && st_reg.limOvr |=> inputLimitCode == $past(st_reg.limField))
    else $error("written limit not applied");
  chk_supply_edge: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ce && (supplyS != st_reg.supplyPrev) && !wrStrobe |=> !st_reg.chgOvr && !st_reg.limOvr)
    else $error("supply change kept overrides");
  chk_suspend: assert property (@(posedge ref_clk) disable iff (!arst_n)
    modeOut == charger_pkg::MODE_SUSPEND |-> isolationOn && !regulatorOn && !trickleOn)
    else $error("suspend paths wrong");
  chk_sys_off: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ce && supplyS && st_reg.regDis
      |=> isolationOn == !$past(chgEff) && !regulatorOn && !trickleOn)
    else $error("isolation does not follow charge enable");
  chk_trickle: assert property (@(posedge ref_clk) disable iff (!arst_n)
    modeOut == charger_pkg::MODE_TRICKLE |-> trickleOn && regulatorOn && !isolationOn)
    else $error("trickle paths wrong");
  chk_weak_fast: assert property (@(posedge ref_clk) disable iff (!arst_n)
    chargeLoopOn |-> trickleOn == (modeOut == charger_pkg::MODE_WEAK))
    else $error("weak/fast trickle path wrong");
  chk_faults: assert property (@(posedge ref_clk) disable iff (!arst_n)
    modeOut == charger_pkg::MODE_SHORTED || modeOut == charger_pkg::MODE_NO_BAT
      |-> regulatorOn && !isolationOn && trickleOn == (modeOut == charger_pkg::MODE_SHORTED))
    else $error("battery fault paths wrong");
  chk_bat_ok: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ce |=> batteryOkOe == $past(!weakS && !deadS && !absentS && !shortS))
    else $error("battery-OK output wrong");

endmodule : charger_mode_control

// ===== logic/charger_pkg.sv
package charger_pkg;

  // Register map (byte addresses on the serial register port)
  localparam logic [7:0] LIMIT_CTRL_ADDR  = 8'h02;
  localparam logic [7:0] MODE_CTRL_ADDR   = 8'h07;
  localparam logic [7:0] STATUS_ADDR      = 8'h0B;
  localparam logic [7:0] UNMAPPED_DATA    = 8'h00;

  // Field positions in charge_mode_control
  localparam int CHG_EN_BIT   = 0;
  localparam int REG_DIS_BIT  = 3;

  // Field layout of the input-limit control register
  localparam int LIM_MSB      = 3;
  localparam int LIM_LSB      = 0;

  // Input-limit codes
  localparam logic [3:0] LIM_100MA  = 4'h0;
  localparam logic [3:0] LIM_500MA  = 4'h6;
  localparam logic [3:0] LIM_1500MA = 4'hB;

  // Reset values
  localparam logic       CHG_EN_RESET  = 1'b0;
  localparam logic       REG_DIS_RESET = 1'b0;
  localparam logic [3:0] LIM_RESET     = LIM_100MA;

  // Serial port framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [6:0] DEV_ADDR_DEF  = 7'h2A;  // Arbitrary bus address

  // Operating modes
  typedef enum logic [8:0] {
    MODE_STANDBY  = 9'h001,
    MODE_SUSPEND  = 9'h002,
    MODE_SYS_OFF  = 9'h004,
    MODE_REG_ONLY = 9'h008,
    MODE_TRICKLE  = 9'h010,
    MODE_WEAK     = 9'h020,
    MODE_FAST     = 9'h040,
    MODE_NO_BAT   = 9'h080,
    MODE_SHORTED  = 9'h100
  } mode_t;

  // Serial port states
  typedef enum logic [6:0] {
    SER_IDLE = 7'h01,
    SER_ADDR = 7'h02,
    SER_REG  = 7'h04,
    SER_WDAT = 7'h08,
    SER_RDAT = 7'h10,
    SER_ACK  = 7'h20,
    SER_MACK = 7'h40
  } ser_state_t;

endpackage : charger_pkg

// ===== logic/level_sync.sv
`timescale 1ns/1ps
// Three-stage synchroniser; a new level is accepted once stages two and three agree
module level_sync #(
  parameter int              WIDTH    = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             ref_clk,   // Core clock
  input  wire logic             arst_n,    // Async reset, active low
  input  wire logic             ce,        // Clock enable
  input  wire logic [WIDTH-1:0] asyncIn,   // Levels from outside the clock domain
  output logic      [WIDTH-1:0] levelOut   // Clean synchronised levels
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } sync_t;

  sync_t st_reg;
  sync_t st_next;

  // Stage one feeds only stage two, so metastability never reaches logic
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = asyncIn;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.level[i] = st_reg.s3[i];
      end
    end
  end

  // State register, frozen while ce is low
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '{s1: RESET_VAL, s2: RESET_VAL, s3: RESET_VAL, level: RESET_VAL};
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign levelOut = st_reg.level;

endmodule : level_sync

// ===== verif/charger_mode_control_bench.sv
`timescale 1ns/1ps
module charger_mode_control_bench;
  logic        ref_clk, arst_n, ce, sclOut, sdaLow, sdaOut, sdaOe, sdaLine;
  logic        chargeEnablePin, highCurrentPin, limitSelectPin, supplyPresent;
  logic        batBelowDead, batBelowWeak, batAbsent, batShorted;
  logic        trickleOn, regulatorOn, chargeLoopOn, isolationOn, batteryOkOut, batteryOkOe;
  logic [3:0]  inputLimitCode, limVal;
  logic [8:0]  modeOut;
  logic [31:0] rnd, cur;
  logic [7:0]  d;
  logic        ok, sup, prevSup, chgOvr, limOvr, chgVal, regDis;
  int          errors, comparisons;
  // Pull-up on the data wire
  assign sdaLine = ~(sdaLow | (sdaOe & ~sdaOut));
  charger_mode_control i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .ce(ce), .sclIn(sclOut),
    .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .chargeEnablePin(chargeEnablePin),
    .highCurrentPin(highCurrentPin), .limitSelectPin(limitSelectPin),
    .supplyPresent(supplyPresent), .batBelowDead(batBelowDead), .batBelowWeak(batBelowWeak),
    .batAbsent(batAbsent), .batShorted(batShorted), .trickleOn(trickleOn),
    .regulatorOn(regulatorOn), .chargeLoopOn(chargeLoopOn), .isolationOn(isolationOn),
    .inputLimitCode(inputLimitCode), .modeOut(modeOut), .batteryOkOut(batteryOkOut),
    .batteryOkOe(batteryOkOe));
  i2c_host_model i_host (.ref_clk(ref_clk), .sdaLine(sdaLine), .sclOut(sclOut), .sdaLow(sdaLow));
  // 50 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xorshift
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic summarize();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  // Reference model: priority of supply, regulator, enable, then battery state
  task automatic compareAll();
    logic e, bd, bw, ba, bs;
    logic [8:0] m;
    logic [3:0] l;
    e = chgOvr ? chgVal : cur[0];
    bd = cur[5];
    bw = cur[5] | cur[6];
    ba = cur[7] & cur[8];
    bs = cur[9] & cur[10];
    l = limOvr ? limVal : (cur[1] ? 4'hB : (cur[2] ? 4'h6 : 4'h0));
    m = !sup ? 9'h001 : regDis ? (e ? 9'h004 : 9'h002) : !e ? 9'h008 : bs ? 9'h100 :
        ba ? 9'h080 : bd ? 9'h010 : bw ? 9'h020 : 9'h040;
    check(16'(modeOut), 16'(m));
    check(16'(inputLimitCode), 16'(l));
    check(16'(trickleOn), 16'((m & 9'h130) != 0));
    check(16'(regulatorOn), 16'((m & 9'h198) != 0));
    check(16'(chargeLoopOn), 16'((m & 9'h060) != 0));
    if ((m & 9'h060) == 0) check(16'(isolationOn), 16'((m & 9'h003) != 0));
    check(16'(batteryOkOe), 16'(!(bw | bd | ba | bs)));
    check(16'({batteryOkOut, sdaOut}), 16'h0000);
    i_host.readReg(charger_pkg::DEV_ADDR_DEF, 8'h07, d, ok);
    check({7'h00, ok, d & 8'h09}, {7'h00, 1'b1, 4'h0, regDis, 2'b00, e});
    i_host.readReg(charger_pkg::DEV_ADDR_DEF, 8'h02, d, ok);
    check({11'h000, ok, d[3:0]}, {11'h001, l});
  endtask : compareAll
  // Hang guard
  initial begin
    repeat (95000) @(posedge ref_clk);
    errors++;
    summarize();
  end
  // Reset, refusals, then random pins, battery states, supply edges and overrides
  initial begin
    {arst_n, chargeEnablePin, highCurrentPin, limitSelectPin, supplyPresent} = 5'h00;
    {batBelowDead, batBelowWeak, batAbsent, batShorted} = 4'h0;
    {prevSup, sup, chgOvr, limOvr, chgVal, regDis} = 6'h00;
    ce = 1'b1;
    limVal = 4'h0;
    cur = 32'h0;
    errors = 0;
    comparisons = 0;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (12) @(posedge ref_clk);
    compareAll();
    // Status after reset: isolation on, battery OK, no overrides, no supply
    i_host.readReg(charger_pkg::DEV_ADDR_DEF, 8'h0B, d, ok);
    check({7'h00, ok, d}, 16'h0188);
    $display("test reset done");
    i_host.readReg(charger_pkg::DEV_ADDR_DEF, 8'h30, d, ok);
    check({7'h00, ok, d}, 16'h0100);
    i_host.readReg(charger_pkg::DEV_ADDR_DEF ^ 7'h01, 8'h07, d, ok);
    check(16'(ok), 16'h0000);
    $display("test refusal done");
    // Clock enable low freezes all state, so a supply pulse goes unseen
    ce <= 1'b0;
    supplyPresent <= 1'b1;
    repeat (10) @(posedge ref_clk);
    check(16'(modeOut), 16'h0001);
    supplyPresent <= 1'b0;
    ce <= 1'b1;
    $display("test clock enable done");
    rnd = 32'h0000000D;
    repeat (30) begin
      rnd = xorshift(rnd);
      cur = rnd;
      sup = rnd[3] | rnd[4];
      chargeEnablePin <= rnd[0];
      highCurrentPin <= rnd[1];
      limitSelectPin <= rnd[2];
      supplyPresent <= sup;
      batBelowDead <= rnd[5];
      batBelowWeak <= rnd[5] | rnd[6];
      batAbsent <= rnd[7] & rnd[8];
      batShorted <= rnd[9] & rnd[10];
      if (sup != prevSup) {chgOvr, limOvr} = 2'b00;
      prevSup = sup;
      repeat (8) @(posedge ref_clk);
      if (rnd[11]) begin
        i_host.writeReg(8'h07, {4'h0, rnd[13] & rnd[14], 2'b00, rnd[15]}, ok);
        check(16'(ok), 16'h0001);
        {chgOvr, chgVal, regDis} = {1'b1, rnd[15], rnd[13] & rnd[14]};
      end
      if (rnd[12]) begin
        i_host.writeReg(8'h02, {4'h0, rnd[19:16]}, ok);
        check(16'(ok), 16'h0001);
        {limOvr, limVal} = {1'b1, rnd[19:16]};
      end
      repeat (4) @(posedge ref_clk);
      compareAll();
    end
    $display("test random sweep done");
    summarize();
  end
endmodule : charger_mode_control_bench

// ===== verif/i2c_host_model.sv
`timescale 1ns/1ps
// Host processor on the serial register port; data is open drain
module i2c_host_model (
  input  wire logic ref_clk,  // Core clock paces the bus
  input  wire logic sdaLine,  // Resolved data wire
  output logic      sclOut,   // Serial clock
  output logic      sdaLow    // High pulls data low
);
  // Bus idles released and high
  initial begin
    sclOut = 1'b1;
    sdaLow = 1'b0;
  end
  // Third of a bit, well above the synchroniser delay of the device
  task automatic waitq();
    repeat (6) @(posedge ref_clk);
  endtask : waitq
  // Start or repeated start: data falls while clock is high
  task automatic start();
    sdaLow <= 1'b0;
    waitq();
    sclOut <= 1'b1;
    waitq();
    sdaLow <= 1'b1;
    waitq();
    sclOut <= 1'b0;
    waitq();
  endtask : start
  task automatic stop();
    sdaLow <= 1'b1;
    waitq();
    sclOut <= 1'b1;
    waitq();
    sdaLow <= 1'b0;
    waitq();
  endtask : stop
  // Data changes only while clock is low; sampled late in the high phase
  task automatic bitx(input logic b, output logic r);
    sdaLow <= ~b;
    waitq();
    sclOut <= 1'b1;
    waitq();
    r = sdaLine;
    sclOut <= 1'b0;
    waitq();
  endtask : bitx
  task automatic byteTx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask : byteTx
  task automatic byteRx(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(last, r);
  endtask : byteRx
  task automatic writeReg(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic k0, k1, k2;
    start();
    byteTx({charger_pkg::DEV_ADDR_DEF, 1'b0}, k0);
    byteTx(a, k1);
    byteTx(d, k2);
    stop();
    ok = k0 & k1 & k2;
  endtask : writeReg
  // A refused address ends the frame at once
  task automatic readReg(input logic [6:0] dev, input logic [7:0] a,
                         output logic [7:0] d, output logic ok);
    logic k;
    d = 8'h00;
    start();
    byteTx({dev, 1'b0}, ok);
    if (ok) begin
      byteTx(a, k);
      start();
      byteTx({dev, 1'b1}, k);
      byteRx(1'b1, d);
    end
    stop();
  endtask : readReg
endmodule : i2c_host_model
